// ### mwm_master.sv
`timescale 1ns/100ps
`default_nettype none
module mwm_master (
   input wire logic ref_clk_in,
   output logic [15:0] od_index_out,
   output logic od_rd_out,
   output logic od_wr_out,
   output logic [31:0] od_wdata_out,
   input wire logic [31:0] od_rdata_in,
   input wire logic od_ack_in,
   input wire logic od_err_in
);
   initial
   begin
      od_index_out = 16'h0;
      od_rd_out = 1'b0;
      od_wr_out = 1'b0;
      od_wdata_out = 32'h0;
   end
   // one-cycle request pulse; index and data turn over once released
   task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] data,
      output logic [31:0] rdata, output logic ack, output logic err);
      @(negedge ref_clk_in);
      od_index_out = idx;
      od_wdata_out = data;
      od_rd_out = !wr;
      od_wr_out = wr;
      @(negedge ref_clk_in);
      od_rd_out = 1'b0;
      od_wr_out = 1'b0;
      od_index_out = ~idx;
      od_wdata_out = ~data;
      rdata = od_rdata_in;
      ack = od_ack_in;
      err = od_err_in;
   endtask
endmodule
`default_nettype wire

// ### mwm_monitor.v
`timescale 1ns/100ps
`default_nettype none
`include "mwm_regs.vh"

module mwm_monitor #(
   parameter [15:0] TICK_CYCLES = `MWM_TICK_CYCLES
)(
   input wire ref_clk_in,
   input wire reset_n_in,
   input wire [7:0] op_mode_in,
   input wire [31:0] position_actual_in,
   input wire [31:0] position_demand_in,
   input wire [31:0] position_target_in,
   input wire [31:0] velocity_ramp_in,
   input wire [31:0] velocity_measured_in,
   input wire [31:0] velocity_setpoint_in,
   input wire [15:0] od_index_in,
   input wire od_rd_in,
   input wire od_wr_in,
   input wire [31:0] od_wdata_in,
   output reg [31:0] od_rdata_out,
   output reg od_ack_out,
   output reg od_err_out,
   output reg [15:0] drive_status_word_out,
   output reg [31:0] velocity_setpoint_out,
   output reg following_error_out,
   output reg error_entry_out,
   output reg [15:0] error_reaction_out
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function [32:0] mwm_absdiff;
      input [31:0] a;
      input [31:0] b;
      reg [32:0] d;
      begin
         d = {a[31], a} - {b[31], b};
         mwm_absdiff = d[32] ? (33'h000000000 - d) : d;
      end
   endfunction

   // ----------------------------------------------------------------------
   // object dictionary storage
   // ----------------------------------------------------------------------
   reg [31:0] following_error_window_r;
   reg [15:0] following_error_timeout_r;
   reg [15:0] deviation_reaction_select_r;
   reg [7:0] error_history_list_r;
   reg [31:0] position_target_window_r;
   reg [15:0] position_window_dwell_ms_r;
   reg [15:0] velocity_target_window_r;
   reg [15:0] velocity_window_dwell_ms_r;
   reg [15:0] zero_speed_threshold_r;
   reg [15:0] zero_speed_dwell_ms_r;

   wire wr_fe_win = od_wr_in && (od_index_in == `MWM_IDX_FE_WIN);
   wire wr_fe_tmo = od_wr_in && (od_index_in == `MWM_IDX_FE_TMO);
   wire wr_react = od_wr_in && (od_index_in == `MWM_IDX_REACT);
   wire wr_pos_win = od_wr_in && (od_index_in == `MWM_IDX_POS_WIN);
   wire wr_pos_dwell = od_wr_in && (od_index_in == `MWM_IDX_POS_DWELL);
   wire wr_vel_win = od_wr_in && (od_index_in == `MWM_IDX_VEL_WIN);
   wire wr_vel_dwell = od_wr_in && (od_index_in == `MWM_IDX_VEL_DWELL);
   wire wr_zs_thr = od_wr_in && (od_index_in == `MWM_IDX_ZS_THR);
   wire wr_zs_dwell = od_wr_in && (od_index_in == `MWM_IDX_ZS_DWELL);

   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         following_error_window_r <= `MWM_RST_FE_WIN;
         following_error_timeout_r <= `MWM_RST_FE_TMO;
         deviation_reaction_select_r <= `MWM_RST_REACT;
         position_target_window_r <= `MWM_RST_POS_WIN;
         position_window_dwell_ms_r <= `MWM_RST_POS_DWELL;
         velocity_target_window_r <= `MWM_RST_VEL_WIN;
         velocity_window_dwell_ms_r <= `MWM_RST_VEL_DWELL;
         zero_speed_threshold_r <= `MWM_RST_ZS_THR;
         zero_speed_dwell_ms_r <= `MWM_RST_ZS_DWELL;
      end
      else
      begin
         if (wr_fe_win)
            following_error_window_r <= od_wdata_in;
         if (wr_fe_tmo)
            following_error_timeout_r <= od_wdata_in[15:0];
         if (wr_react)
            deviation_reaction_select_r <= od_wdata_in[15:0];
         if (wr_pos_win)
            position_target_window_r <= od_wdata_in;
         if (wr_pos_dwell)
            position_window_dwell_ms_r <= od_wdata_in[15:0];
         if (wr_vel_win)
            velocity_target_window_r <= od_wdata_in[15:0];
         if (wr_vel_dwell)
            velocity_window_dwell_ms_r <= od_wdata_in[15:0];
         if (wr_zs_thr)
            zero_speed_threshold_r <= od_wdata_in[15:0];
         if (wr_zs_dwell)
            zero_speed_dwell_ms_r <= od_wdata_in[15:0];
      end
   end

   // ----------------------------------------------------------------------
   // millisecond tick
   // ----------------------------------------------------------------------
   reg [15:0] tick_cnt_r;
   reg tick_r;

   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         tick_cnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end
      else if (tick_cnt_r == (TICK_CYCLES - 16'h0001))
      begin
         tick_cnt_r <= 16'h0000;
         tick_r <= 1'b1;
      end
      else
      begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // window conditions
   // ----------------------------------------------------------------------
   wire [32:0] fe_dev = mwm_absdiff(position_actual_in, position_demand_in);
   wire [32:0] pos_dev = mwm_absdiff(position_actual_in, position_target_in);
   wire [32:0] vel_dev = mwm_absdiff(velocity_measured_in, velocity_setpoint_in);
   wire [32:0] vel_mag = mwm_absdiff(velocity_measured_in, 32'h00000000);
   wire mode_pos = (op_mode_in == `MWM_MODE_PP) || (op_mode_in == `MWM_MODE_IP);
   wire mode_pv = (op_mode_in == `MWM_MODE_PV);

   wire [3:0] cond;
   wire [63:0] limit;
   wire [3:0] done;

   // deviation above window, all ones turns the check off
   assign cond[0] = (following_error_window_r != `MWM_WIN_OFF) &&
                    (fe_dev > {1'b0, following_error_window_r});
   // symmetric position window in position modes only
   assign cond[1] = mode_pos && (position_target_window_r != `MWM_WIN_OFF) &&
                    (pos_dev < {1'b0, position_target_window_r});
   assign cond[2] = mode_pv && (vel_dev < {17'h00000, velocity_target_window_r});
   assign cond[3] = mode_pv && (vel_mag > {17'h00000, zero_speed_threshold_r});

   assign limit = {zero_speed_dwell_ms_r, velocity_window_dwell_ms_r,
                   position_window_dwell_ms_r, following_error_timeout_r};

   // ----------------------------------------------------------------------
   // dwell timers
   // ----------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_dwell
         reg [16:0] cnt_r;
         always @(posedge ref_clk_in or negedge reset_n_in)
         begin
            if (!reset_n_in)
               cnt_r <= 17'h00000;
            else if (!cond[gi])
               cnt_r <= 17'h00000;
            else if (tick_r && (cnt_r != 17'h1ffff))
               cnt_r <= cnt_r + 17'h00001;
         end
         // threshold dwell only has to reach its limit, window dwells must pass it
         if (gi == 3)
         begin : g_ge
            assign done[gi] = cond[gi] && (cnt_r >= {1'b0, limit[gi*16 +: 16]});
         end
         else
         begin : g_gt
            assign done[gi] = cond[gi] && (cnt_r > {1'b0, limit[gi*16 +: 16]});
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // status word and error reaction
   // ----------------------------------------------------------------------
   reg [15:0] status_nxt;

   always @*
   begin
      status_nxt = 16'h0000;
      status_nxt[`MWM_SW_FOLLOW_BIT] = done[0];
      status_nxt[`MWM_SW_TARGET_BIT] = done[1] | done[2];
      // cleared only while speed is confirmed nonzero
      status_nxt[`MWM_SW_SPEED_BIT] = ~done[3];
   end

   // an error entry is made once per rising edge of the following error flag while the reaction select is nonzero
   wire fe_rise = done[0] && !following_error_out;

   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         drive_status_word_out <= `MWM_RST_STATUS;
         following_error_out <= 1'b0;
         error_entry_out <= 1'b0;
         error_reaction_out <= 16'h0000;
         error_history_list_r <= 8'h00;
         velocity_setpoint_out <= 32'h00000000;
      end
      else
      begin
         drive_status_word_out <= status_nxt;
         following_error_out <= done[0];
         // ramp output feeds the velocity controller
         velocity_setpoint_out <= velocity_ramp_in;
         // reaction and history entry only when configured
         error_entry_out <= fe_rise && (deviation_reaction_select_r != 16'h0000);
         if (fe_rise && (deviation_reaction_select_r != 16'h0000))
         begin
            error_reaction_out <= deviation_reaction_select_r;
            if (error_history_list_r != 8'hff)
               error_history_list_r <= error_history_list_r + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------------
   // object dictionary read and answer
   // ----------------------------------------------------------------------
   reg [31:0] rd_nxt;
   reg hit_nxt;
   reg ro_nxt;

   always @*
   begin
      rd_nxt = 32'h00000000;
      hit_nxt = 1'b1;
      ro_nxt = 1'b0;
      case (od_index_in)
         `MWM_IDX_STATUS:
         begin
            rd_nxt = {16'h0000, drive_status_word_out};
            ro_nxt = 1'b1;
         end
         `MWM_IDX_FE_WIN: rd_nxt = following_error_window_r;
         `MWM_IDX_FE_TMO: rd_nxt = {16'h0000, following_error_timeout_r};
         `MWM_IDX_REACT: rd_nxt = {16'h0000, deviation_reaction_select_r};
         `MWM_IDX_ERR_HIST:
         begin
            rd_nxt = {24'h000000, error_history_list_r};
            ro_nxt = 1'b1;
         end
         `MWM_IDX_POS_WIN: rd_nxt = position_target_window_r;
         `MWM_IDX_POS_DWELL: rd_nxt = {16'h0000, position_window_dwell_ms_r};
         // demand value is the ramp output
         `MWM_IDX_VEL_RAMP:
         begin
            rd_nxt = velocity_ramp_in;
            ro_nxt = 1'b1;
         end
         `MWM_IDX_VEL_MEAS:
         begin
            rd_nxt = velocity_measured_in;
            ro_nxt = 1'b1;
         end
         `MWM_IDX_VEL_WIN: rd_nxt = {16'h0000, velocity_target_window_r};
         `MWM_IDX_VEL_DWELL: rd_nxt = {16'h0000, velocity_window_dwell_ms_r};
         `MWM_IDX_ZS_THR: rd_nxt = {16'h0000, zero_speed_threshold_r};
         `MWM_IDX_ZS_DWELL: rd_nxt = {16'h0000, zero_speed_dwell_ms_r};
         default: hit_nxt = 1'b0;
      endcase
   end

   always @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         od_rdata_out <= 32'h00000000;
         od_ack_out <= 1'b0;
         od_err_out <= 1'b0;
      end
      else
      begin
         od_ack_out <= od_rd_in | od_wr_in;
         // unknown index, or a write to a read-only object, is refused
         od_err_out <= (od_rd_in | od_wr_in) && (!hit_nxt || (od_wr_in && ro_nxt));
         od_rdata_out <= (od_rd_in && hit_nxt) ? rd_nxt : 32'h00000000;
      end
   end

endmodule

`default_nettype wire

// ### mwm_monitor_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "mwm_regs.vh"
module mwm_monitor_chk #(
   parameter [15:0] TICK_CYCLES = `MWM_TICK_CYCLES
)(
   input wire ref_clk_in,
   input wire reset_n_in,
   input wire [7:0] op_mode_in,
   input wire [31:0] velocity_ramp_in,
   input wire [15:0] od_index_in,
   input wire od_rd_in,
   input wire od_wr_in,
   input wire [31:0] od_rdata_out,
   input wire od_ack_out,
   input wire od_err_out,
   input wire [15:0] drive_status_word_out,
   input wire [31:0] velocity_setpoint_out,
   input wire following_error_out,
   input wire error_entry_out
);
   // ---------------------------------------------------------------
   // object access and status relations
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_req;
      od_rd_in || od_wr_in;
   endsequence
   sequence s_ro_write;
      od_wr_in && (od_index_in == `MWM_IDX_VEL_MEAS || od_index_in == `MWM_IDX_VEL_RAMP);
   endsequence
   a_ack_follows_req: assert property (s_req |=> od_ack_out)
      else $error("request without answer");
   a_ack_needs_req: assert property (od_ack_out |-> $past(od_rd_in || od_wr_in))
      else $error("answer without request");
   a_ro_write_err: assert property (s_ro_write |=> od_err_out)
      else $error("read-only write accepted");
   a_rdata_quiet: assert property (!od_ack_out || od_err_out |-> od_rdata_out == 32'h0)
      else $error("read data outside answer");
   a_ramp_copy: assert property (reset_n_in |=> velocity_setpoint_out == $past(velocity_ramp_in))
      else $error("setpoint not ramp output");
   a_fe_mirror: assert property (following_error_out == drive_status_word_out[13])
      else $error("following flag differs from status");
   a_entry_single: assert property (error_entry_out |=> !error_entry_out)
      else $error("history entry pulse too long");
   a_entry_with_fe: assert property (error_entry_out |-> ##[0:1] following_error_out)
      else $error("history entry without following error");
   a_spare_bits_zero: assert property ((drive_status_word_out & 16'hcbff) == 16'h0)
      else $error("unused status bits set");
   wire win_mode = (op_mode_in == `MWM_MODE_PP) || (op_mode_in == `MWM_MODE_IP) ||
      (op_mode_in == `MWM_MODE_PV);
   a_target_mode_gate: assert property (!win_mode |=> !drive_status_word_out[10])
      else $error("target bit outside window modes");
   a_speed_bit_non_pv: assert property (op_mode_in != `MWM_MODE_PV |=> drive_status_word_out[12])
      else $error("zero speed bit cleared outside velocity mode");
endmodule
bind mwm_monitor mwm_monitor_chk #(.TICK_CYCLES(TICK_CYCLES)) i_mwm_monitor_chk (
   .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .op_mode_in(op_mode_in),
   .velocity_ramp_in(velocity_ramp_in), .od_index_in(od_index_in), .od_rd_in(od_rd_in),
   .od_wr_in(od_wr_in), .od_rdata_out(od_rdata_out), .od_ack_out(od_ack_out),
   .od_err_out(od_err_out), .drive_status_word_out(drive_status_word_out),
   .velocity_setpoint_out(velocity_setpoint_out), .following_error_out(following_error_out),
   .error_entry_out(error_entry_out));
`default_nettype wire

// ### mwm_monitor_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "mwm_regs.vh"
module mwm_monitor_tb;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] mode = 8'h0;
   logic [31:0] p_act = 0, p_dem = 0, p_tgt = 32'h10000, ramp = 32'h1234, meas = 32'hfffffff0;
   logic [31:0] v_set = 0, rdat, od_wdata, od_rdata, vel_sp;
   logic [15:0] od_index, status, react;
   logic od_rd, od_wr, od_ack, od_err, fe, entry, ack, err;
   integer error_cnt = 0, samples_checked = 0, n_entry = 0;
   initial forever #20 clk = ~clk;
   always @(posedge clk) if (entry) n_entry <= n_entry + 1;
   mwm_master i_mwm_master (.ref_clk_in(clk), .od_index_out(od_index), .od_rd_out(od_rd),
      .od_wr_out(od_wr), .od_wdata_out(od_wdata), .od_rdata_in(od_rdata), .od_ack_in(od_ack),
      .od_err_in(od_err));
   mwm_monitor #(.TICK_CYCLES(16'd4)) i_mwm_monitor (.ref_clk_in(clk), .reset_n_in(reset_n),
      .op_mode_in(mode), .position_actual_in(p_act), .position_demand_in(p_dem),
      .position_target_in(p_tgt), .velocity_ramp_in(ramp), .velocity_measured_in(meas),
      .velocity_setpoint_in(v_set), .od_index_in(od_index), .od_rd_in(od_rd), .od_wr_in(od_wr),
      .od_wdata_in(od_wdata), .od_rdata_out(od_rdata), .od_ack_out(od_ack), .od_err_out(od_err),
      .drive_status_word_out(status), .velocity_setpoint_out(vel_sp),
      .following_error_out(fe), .error_entry_out(entry), .error_reaction_out(react));
   // ---------------------------------------------------------------
   // shared helpers
   // ---------------------------------------------------------------
   task wrap_up;
      $display("checks=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task acc(input logic wr, input logic [15:0] idx, input logic [31:0] d, input logic e);
      i_mwm_master.access(wr, idx, d, rdat, ack, err);
      chk({31'h0, ack}, 32'h1);
      chk({31'h0, err}, {31'h0, e});
   endtask
   task rd(input logic [15:0] idx, input logic [31:0] exp, input logic e);
      acc(1'b0, idx, 32'h0, e);
      chk(rdat, exp);
   endtask
   task wait_bit(input integer b, input logic v, input integer lim);
      integer n;
      n = 0;
      while (status[b] !== v && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      chk({31'h0, status[b]}, {31'h0, v});
      if (status[b] !== v)
         wrap_up;
   endtask
   task hold_bit(input integer b, input logic v, input integer n);
      repeat (n)
      begin
         @(negedge clk);
         chk({31'h0, status[b]}, {31'h0, v});
      end
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_regs;
      chk({16'h0, status}, 32'h1000);
      rd(`MWM_IDX_STATUS, 32'h1000, 1'b0);
      rd(`MWM_IDX_POS_WIN, 32'ha, 1'b0);
      rd(`MWM_IDX_POS_DWELL, 32'h64, 1'b0);
      rd(`MWM_IDX_VEL_WIN, 32'h1e, 1'b0);
      rd(`MWM_IDX_VEL_DWELL, 32'h0, 1'b0);
      rd(16'h6000, 32'h0, 1'b1);
      acc(1'b1, `MWM_IDX_VEL_MEAS, 32'h5, 1'b1);
      rd(`MWM_IDX_VEL_MEAS, meas, 1'b0);
      acc(1'b1, `MWM_IDX_VEL_RAMP, 32'h1, 1'b1);
      rd(`MWM_IDX_VEL_RAMP, ramp, 1'b0);
      chk(vel_sp, ramp);
      $display("t_regs done");
   endtask
   task t_follow;
      mode = `MWM_MODE_PP;
      acc(1'b1, `MWM_IDX_FE_WIN, 32'h5, 1'b0);
      acc(1'b1, `MWM_IDX_FE_TMO, 32'h2, 1'b0);
      acc(1'b1, `MWM_IDX_REACT, 32'h1, 1'b0);
      p_act = 32'h5;
      hold_bit(13, 1'b0, 24);
      p_act = 32'h6;
      hold_bit(13, 1'b0, 6);
      wait_bit(13, 1'b1, 20);
      chk({31'h0, fe}, 32'h1);
      // the pulse counter only sees the entry one edge after the flag rises
      @(negedge clk);
      chk(n_entry, 32'h1);
      chk({16'h0, react}, 32'h1);
      rd(`MWM_IDX_ERR_HIST, 32'h1, 1'b0);
      acc(1'b1, `MWM_IDX_FE_WIN, `MWM_WIN_OFF, 1'b0);
      wait_bit(13, 1'b0, 3);
      $display("t_follow done");
   endtask
   task t_position;
      p_tgt = 32'd1000;
      acc(1'b1, `MWM_IDX_POS_DWELL, 32'h2, 1'b0);
      p_act = 32'd991;
      hold_bit(10, 1'b0, 6);
      wait_bit(10, 1'b1, 20);
      p_act = 32'd1010;
      wait_bit(10, 1'b0, 3);
      p_act = 32'd1009;
      wait_bit(10, 1'b1, 20);
      mode = `MWM_MODE_IP;
      hold_bit(10, 1'b1, 4);
      mode = 8'h02;
      wait_bit(10, 1'b0, 3);
      mode = `MWM_MODE_PP;
      acc(1'b1, `MWM_IDX_POS_WIN, `MWM_WIN_OFF, 1'b0);
      hold_bit(10, 1'b0, 24);
      $display("t_position done");
   endtask
   task t_velocity;
      acc(1'b1, `MWM_IDX_ZS_THR, 32'd529, 1'b0);
      acc(1'b1, `MWM_IDX_ZS_DWELL, 32'h2, 1'b0);
      acc(1'b1, `MWM_IDX_VEL_DWELL, 32'h3, 1'b0);
      mode = `MWM_MODE_PV;
      v_set = 32'd500;
      meas = 32'd529;
      hold_bit(10, 1'b0, 8);
      hold_bit(12, 1'b1, 1);
      meas = 32'd600;
      @(negedge clk);
      meas = 32'd529;
      hold_bit(10, 1'b0, 12);
      wait_bit(10, 1'b1, 24);
      acc(1'b1, `MWM_IDX_ZS_THR, 32'd528, 1'b0);
      wait_bit(12, 1'b0, 16);
      meas = -32'd529;
      hold_bit(12, 1'b0, 4);
      mode = `MWM_MODE_PP;
      wait_bit(12, 1'b1, 3);
      $display("t_velocity done");
   endtask
   task t_reset;
      @(negedge clk);
      reset_n = 1'b0;
      @(negedge clk);
      chk({16'h0, status}, 32'h1000);
      chk({31'h0, fe}, 32'h0);
      reset_n = 1'b1;
      rd(`MWM_IDX_FE_WIN, 32'h100, 1'b0);
      rd(`MWM_IDX_FE_TMO, 32'h64, 1'b0);
      rd(`MWM_IDX_ERR_HIST, 32'h0, 1'b0);
      $display("t_reset done");
   endtask
   initial
   begin
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      t_regs;
      t_follow;
      t_position;
      t_velocity;
      t_reset;
      wrap_up;
   end
endmodule
`default_nettype wire

// ### mwm_regs.vh
`ifndef MWM_REGS_VH
`define MWM_REGS_VH

// ----------------------------------------------------------------------
// object dictionary indices
// ----------------------------------------------------------------------
`define MWM_IDX_STATUS 16'h6041
`define MWM_IDX_FE_WIN 16'h6065
`define MWM_IDX_FE_TMO 16'h6066
`define MWM_IDX_REACT 16'h3700
`define MWM_IDX_ERR_HIST 16'h1003
`define MWM_IDX_POS_WIN 16'h6067
`define MWM_IDX_POS_DWELL 16'h6068
`define MWM_IDX_VEL_RAMP 16'h606b
`define MWM_IDX_VEL_MEAS 16'h606c
`define MWM_IDX_VEL_WIN 16'h606d
`define MWM_IDX_VEL_DWELL 16'h606e
`define MWM_IDX_ZS_THR 16'h606f
`define MWM_IDX_ZS_DWELL 16'h6070

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MWM_RST_FE_WIN 32'h00000100
`define MWM_RST_FE_TMO 16'h0064
`define MWM_RST_REACT 16'h0000
`define MWM_RST_POS_WIN 32'h0000000a
`define MWM_RST_POS_DWELL 16'h0064
`define MWM_RST_VEL_WIN 16'h001e
`define MWM_RST_VEL_DWELL 16'h0000
`define MWM_RST_ZS_THR 16'h0000
`define MWM_RST_ZS_DWELL 16'h0000
`define MWM_RST_STATUS 16'h1000

// ----------------------------------------------------------------------
// status word bits, special values, modes
// ----------------------------------------------------------------------
`define MWM_SW_TARGET_BIT 10
`define MWM_SW_SPEED_BIT 12
`define MWM_SW_FOLLOW_BIT 13
`define MWM_WIN_OFF 32'hffffffff
`define MWM_MODE_PP 8'h01
`define MWM_MODE_PV 8'h03
`define MWM_MODE_IP 8'h07

// ----------------------------------------------------------------------
// timing: one millisecond tick from a 40 ns clock
// ----------------------------------------------------------------------
`define MWM_TICK_CYCLES 16'h61a8

`endif
